// File: logic/tdcs_top.sv
// Code set selection, lane rotation and error-rate estimator of the decoder
// Function
// - Hybrid or parallel architecture chosen by a build parameter.
// - Lane rotation exists only when the error estimator is built in.
// - Estimator re-encodes decoded bits and compares with received symbols.
// - For TCM sets the error count carries no meaningful value.
// - Rotated lane i takes input lane ((offset + i - 1) mod N) + 1.
// - Input bus is N lanes of soft width; offset lies in 0..N-1.
// - One to eight code sets, each a rate and its polynomials.
// - N is 2..7 hybrid, 2..4 parallel, at most 5 distinct values.
// - TCM sets use exactly two coded bits per information bit.
// - Each set has constraint length 3..9, 2^(L-1) trellis states.
// - Viterbi or TCM chosen per set; mixed sets may coexist.
// - Parallel uses first four polynomials; hybrid up to seven.
// - Hybrid with L of 3 or 4 ignores upper end-state bits.
// - Parallel offers None, Continuous, Block; best-state search under None.
// - Polynomials held in decimal in the design.
// - Soft width 1..16; width one means hard decisions plus erasures.
`timescale 1ns/10ps
module tdcs_top
  import tdcs_pkg::*;
#(
  parameter logic [1:0] ARCH       = ARCH_HYBRID,
  parameter bit         BER_ON     = 1'b1,
  parameter bit         NODE_SYNC  = 1'b1,
  parameter int         NUM_SETS   = NSETS,
  parameter logic [1:0] OPTIMIZE   = OPT_NONE,
  parameter bit         BEST_STATE = 1'b1
)(
  input  wire logic                               clk_sys_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               clk_en_i,
  input  wire logic                               sym_valid_i,
  output logic                                    sym_ready_o,
  input  wire logic [LANES_MAX-1:0][SOFT_W-1:0]   soft_symbol_lanes_in_i,
  input  wire logic [LANES_MAX-1:0]               erase_i,
  input  wire logic                               dec_bit_i,
  input  wire logic [tdcs_pkg::SEL_W-1:0]         sel_code_i,
  input  wire logic [tdcs_pkg::NUM_W-1:0]         rot_offset_i,
  input  wire logic [tdcs_pkg::END_W-1:0]         trellis_end_state_in_i,
  input  wire logic                               err_clear_i,
  output logic                                    out_valid_o,
  input  wire logic                               out_ready_i,
  output logic [LANES_MAX-1:0][SOFT_W-1:0]        rotated_symbol_lanes_o,
  output logic [tdcs_pkg::SEL_W-1:0]              out_sel_o,
  output logic [tdcs_pkg::NUM_W-1:0]              out_n_coded_o,
  output logic [tdcs_pkg::LEN_W-1:0]              out_con_len_o,
  output logic                                    out_tcm_o,
  output logic [NPOLY-1:0][POLY_W-1:0]            out_poly_o,
  output logic [tdcs_pkg::END_W-1:0]              end_state_o,
  output logic                                    best_state_en_o,
  output logic [tdcs_pkg::ERR_W-1:0]              num_err_o,
  output logic                                    err_valid_o,
  output logic                                    cfg_error_o
);
  import tdcs_pkg::*;

  // Build-time legality of the configuration
  function automatic logic cfg_bad();
    logic bad;
    logic [N_MAX_HYB:0] seen;
    int distinct;
    bad = 1'b0;
    seen = '0;
    distinct = 0;
    if (NUM_SETS < 1 || NUM_SETS > NSETS) bad = 1'b1;
    if (NODE_SYNC && !BER_ON) bad = 1'b1;
    for (int s = 0; s < NSETS; s++) begin
      if (s < NUM_SETS) begin
        if (SET_TABLE[s].n_coded < N_MIN) bad = 1'b1;
        if (ARCH == ARCH_HYBRID && SET_TABLE[s].n_coded > N_MAX_HYB)
          bad = 1'b1;
        if (ARCH == ARCH_PARALLEL && SET_TABLE[s].n_coded > N_MAX_PAR)
          bad = 1'b1;
        if (SET_TABLE[s].mode == MODE_TCM && SET_TABLE[s].n_coded != N_TCM)
          bad = 1'b1;
        if (SET_TABLE[s].con_len < L_MIN || SET_TABLE[s].con_len > L_MAX)
          bad = 1'b1;
        if (!seen[SET_TABLE[s].n_coded]) distinct++;
        seen[SET_TABLE[s].n_coded] = 1'b1;
      end
    end
    if (distinct > N_DISTINCT) bad = 1'b1;
    if (ARCH != ARCH_HYBRID && ARCH != ARCH_PARALLEL) bad = 1'b1;
    if (ARCH == ARCH_PARALLEL && OPTIMIZE > OPT_BLOCK) bad = 1'b1;
    return bad;
  endfunction

  localparam logic CFG_BAD = cfg_bad();
  localparam bit ROT_ON = NODE_SYNC && BER_ON;
  localparam bit BEST_ON = (ARCH == ARCH_HYBRID) ||
                           (OPTIMIZE == OPT_NONE && BEST_STATE);

  tdcs_word_t in_word, buf_word;
  logic       buf_valid, buf_ready;
  logic       sel_ok;
  tdcs_set_t  cur_set;

  assign sel_ok = ({29'h0, sel_code_i} < NUM_SETS);
  assign cur_set = SET_TABLE[sel_ok ? sel_code_i : '0];

  // Rotation uses the set's own N; an offset at or above N is replaced by zero
  logic [LANES_MAX-1:0][SOFT_W-1:0] rot_lanes;
  logic [LANES_MAX-1:0]             rot_erase;
  logic [NUM_W-1:0] offs;
  assign offs = (rot_offset_i < cur_set.n_coded) ? rot_offset_i : '0;

  genvar gi;
  generate
    for (gi = 0; gi < LANES_MAX; gi++) begin : g_rot
      logic [NUM_W:0] idx;
      logic [NUM_W:0] wrapped;
      assign idx = {1'b0, offs} + (NUM_W+1)'(gi);
      assign wrapped = (idx >= {1'b0, cur_set.n_coded}) ?
                       idx - {1'b0, cur_set.n_coded} : idx;
      assign rot_lanes[gi] = !ROT_ON ? soft_symbol_lanes_in_i[gi] :
                             (gi >= cur_set.n_coded) ? '0 :
                             soft_symbol_lanes_in_i[wrapped[NUM_W-1:0]];
      // Erase marks follow their lanes, or they would flag the wrong symbol
      assign rot_erase[gi] = !ROT_ON ? erase_i[gi] :
                             (gi >= cur_set.n_coded) ? 1'b0 :
                             erase_i[wrapped[NUM_W-1:0]];
    end
  endgenerate

  always_comb begin
    in_word          = '0;
    in_word.lanes    = rot_lanes;
    in_word.erase    = rot_erase;
    in_word.info_bit = dec_bit_i;
    // End state travels with its word so a stall cannot mix blocks
    in_word.end_st   = trellis_end_state_in_i;
    in_word.sel      = sel_ok ? sel_code_i : '0;
  end

  tdcs_skid_buf u_buf (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (sym_valid_i),
    .in_ready_o  (sym_ready_o),
    .in_data_i   (in_word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_word)
  );

  // Output stage and estimator share one registered handshake
  tdcs_set_t             bset;
  logic [SHIFT_W-1:0]    shreg, next_shreg;
  logic [ERR_W-1:0]      err_cnt, next_err_cnt;
  logic                  oval, next_oval;
  logic [LANES_MAX-1:0][SOFT_W-1:0] olanes, next_olanes;
  logic [SEL_W-1:0]      osel, next_osel;
  logic [END_W-1:0]      oend, next_oend;
  logic                  otcm, next_otcm;
  logic [SHIFT_W:0]      enc_reg;
  logic [NUM_W:0]        mism;

  assign bset = SET_TABLE[buf_word.sel];
  assign buf_ready = !oval || out_ready_i;
  assign enc_reg = {shreg, buf_word.info_bit};

  // Re-encode the decoded bit and count hard mismatches per lane
  always_comb begin
    logic c;
    mism = '0;
    c = 1'b0;
    for (int p = 0; p < NPOLY; p++) begin
      c = ^(enc_reg & bset.poly[p]);
      if (p < bset.n_coded && !buf_word.erase[p] &&
          (ARCH == ARCH_HYBRID || p < NPOLY_PAR)) begin
        // Sign bit of a soft symbol is set for a received one
        if (c != buf_word.lanes[p][SOFT_W-1]) mism = mism + 1'b1;
      end
    end
  end

  always_comb begin
    next_shreg   = shreg;
    next_err_cnt = err_cnt;
    next_oval    = oval;
    next_olanes  = olanes;
    next_osel    = osel;
    next_oend    = oend;
    next_otcm    = otcm;
    if (buf_ready) begin
      next_oval = buf_valid;
    end
    if (buf_valid && buf_ready) begin
      next_olanes = buf_word.lanes;
      next_osel   = buf_word.sel;
      next_otcm   = (bset.mode == MODE_TCM);
      next_oend   = buf_word.end_st;
      if (ARCH == ARCH_HYBRID && bset.con_len <= L_SMALL_MAX)
        next_oend = {{(END_W-END_W_MIN){1'b0}},
                     buf_word.end_st[END_W_MIN-1:0]};
      next_shreg = {shreg[SHIFT_W-2:0], buf_word.info_bit};
    end
    if (err_clear_i) begin
      next_err_cnt = '0;
    end
    // Clear and count together leave only this word's mismatches; TCM words add nothing
    if (BER_ON && buf_valid && buf_ready && bset.mode != MODE_TCM) begin
      next_err_cnt = (err_clear_i ? '0 : err_cnt) +
                     ERR_W'(mism);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shreg   <= '0;
      err_cnt <= '0;
      oval    <= 1'b0;
      olanes  <= '0;
      osel    <= '0;
      oend    <= '0;
      otcm    <= 1'b0;
    end else if (clk_en_i) begin
      shreg   <= next_shreg;
      err_cnt <= next_err_cnt;
      oval    <= next_oval;
      olanes  <= next_olanes;
      osel    <= next_osel;
      oend    <= next_oend;
      otcm    <= next_otcm;
    end
  end

  tdcs_set_t oset;
  assign oset = SET_TABLE[osel];

  // Parallel builds see only the first four polynomials
  always_comb begin
    out_poly_o = oset.poly;
    if (ARCH == ARCH_PARALLEL) begin
      for (int p = NPOLY_PAR; p < NPOLY; p++) out_poly_o[p] = '0;
    end
  end

  assign out_valid_o            = oval;
  assign rotated_symbol_lanes_o = olanes;
  assign out_sel_o              = osel;
  assign out_n_coded_o          = oset.n_coded;
  assign out_con_len_o          = oset.con_len;
  assign out_tcm_o              = otcm;
  assign end_state_o            = oend;
  assign best_state_en_o        = BEST_ON;
  assign num_err_o              = BER_ON ? err_cnt : '0;
  assign err_valid_o            = BER_ON && oval && !otcm;
  assign cfg_error_o            = CFG_BAD;
endmodule

// File: logic/tdcs_pkg.sv
// Package with constants, code set table and carrier types of the decoder
package tdcs_pkg;
  localparam int SOFT_W      = 4;
  localparam int LANES_MAX   = 7;
  localparam int NSETS       = 8;
  localparam int SEL_W       = 3;
  localparam int POLY_W      = 9;
  localparam int NPOLY       = 7;
  localparam int NPOLY_PAR   = 4;
  localparam int LEN_W       = 4;
  localparam int NUM_W       = 3;
  localparam int END_W       = 8;
  localparam int END_W_MIN   = 4;
  localparam int ERR_W       = 16;
  localparam int SHIFT_W     = 8;
  localparam int BUF_DEPTH   = 2;
  localparam int L_MIN       = 3;
  localparam int L_MAX       = 9;
  localparam int L_SMALL_MAX = 4;
  localparam int N_MIN       = 2;
  localparam int N_MAX_HYB   = 7;
  localparam int N_MAX_PAR   = 4;
  localparam int N_DISTINCT  = 5;
  localparam int N_TCM       = 2;
  localparam logic [1:0] ARCH_HYBRID   = 2'h0;
  localparam logic [1:0] ARCH_PARALLEL = 2'h1;
  localparam logic [1:0] OPT_NONE      = 2'h0;
  localparam logic [1:0] OPT_CONT      = 2'h1;
  localparam logic [1:0] OPT_BLOCK     = 2'h2;

  typedef enum logic {MODE_VITERBI, MODE_TCM} tdcs_mode_t;

  typedef struct packed {
    logic [NUM_W-1:0] n_coded;
    logic [LEN_W-1:0] con_len;
    tdcs_mode_t       mode;
    logic [NPOLY-1:0][POLY_W-1:0] poly;
  } tdcs_set_t;

  typedef struct packed {
    logic [LANES_MAX-1:0][SOFT_W-1:0] lanes;
    logic [LANES_MAX-1:0]             erase;
    logic                             info_bit;
    logic [END_W-1:0]                 end_st;
    logic [SEL_W-1:0]                 sel;
  } tdcs_word_t;

  // Generator polynomials held as decimal literals (octal 7,5 -> 7,5 etc.)
  localparam tdcs_set_t SET_TABLE [NSETS] = '{
    '{3'd2, 4'd3, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd0,9'd5,9'd7}},
    '{3'd2, 4'd7, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd0,9'd91,9'd121}},
    '{3'd3, 4'd5, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd27,9'd25,9'd19}},
    '{3'd4, 4'd4, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd15,9'd13,9'd11,9'd9}},
    '{3'd2, 4'd3, MODE_TCM,     '{9'd0,9'd0,9'd0,9'd0,9'd0,9'd5,9'd7}},
    '{3'd2, 4'd9, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd0,9'd335,9'd491}},
    '{3'd3, 4'd6, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd55,9'd47,9'd39}},
    '{3'd2, 4'd5, MODE_VITERBI, '{9'd0,9'd0,9'd0,9'd0,9'd0,9'd19,9'd23}}
  };
endpackage

// File: logic/tdcs_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module tdcs_skid_buf
  import tdcs_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire tdcs_word_t in_data_i,
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output tdcs_word_t      out_data_o
);
  tdcs_word_t mem [BUF_DEPTH];
  tdcs_word_t next_mem [BUF_DEPTH];
  logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic       push, pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    case ({push, pop})
      2'b10:   next_count = count + 2'h1;
      2'b01:   next_count = count - 2'h1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      for (int k = 0; k < BUF_DEPTH; k++) begin
        mem[k] <= '0;
      end
    end else if (clk_en_i) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end
endmodule

// File: tb/tdcs_top_props.sv
// Checker of the decoder output stage, bound to its top module
`timescale 1ns/10ps
module tdcs_top_props
  import tdcs_pkg::*;
#(
  parameter int NUM_SETS = NSETS
)(
  input wire logic                             clk_sys_i,
  input wire logic                             sys_rst_i,
  input wire logic                             clk_en_i,
  input wire logic                             sym_valid_i,
  input wire logic                             sym_ready_o,
  input wire logic                             out_valid_o,
  input wire logic                             out_ready_i,
  input wire logic [LANES_MAX-1:0][SOFT_W-1:0] rotated_symbol_lanes_o,
  input wire logic [SEL_W-1:0]                 out_sel_o,
  input wire logic [NUM_W-1:0]                 out_n_coded_o,
  input wire logic [LEN_W-1:0]                 out_con_len_o,
  input wire logic                             out_tcm_o,
  input wire logic [ERR_W-1:0]                 num_err_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  logic take;
  assign take = sym_valid_i && sym_ready_o && clk_en_i;
  // Lanes past the set's coded count must read zero
  function automatic logic hi_zero(
    logic [LANES_MAX-1:0][SOFT_W-1:0] l, logic [NUM_W-1:0] n);
    hi_zero = 1'b1;
    for (int p = 0; p < LANES_MAX; p++)
      if (p >= n && l[p] != '0) hi_zero = 1'b0;
  endfunction
  a_reset_idle: assert property ($fell(sys_rst_i) |->
    !out_valid_o && sym_ready_o && num_err_o == '0)
    else $error("outputs not idle after reset");
  a_hold_stall: assert property (out_valid_o && !(out_ready_i && clk_en_i)
    |=> out_valid_o && $stable(rotated_symbol_lanes_o) && $stable(out_sel_o))
    else $error("output word changed while stalled");
  a_take_latency: assert property (take ##1 clk_en_i |=> out_valid_o)
    else $error("taken word late at output");
  a_freeze_off: assert property (!clk_en_i |=>
    $stable(num_err_o) && $stable(out_valid_o))
    else $error("state moved with clock enable low");
  a_n_lookup: assert property (out_valid_o |->
    out_n_coded_o == SET_TABLE[out_sel_o].n_coded && out_n_coded_o >= N_MIN)
    else $error("coded bit count wrong");
  a_tcm_two: assert property (out_valid_o && out_tcm_o |->
    out_n_coded_o == N_TCM) else $error("TCM set without two bits");
  a_mode_lookup: assert property (out_valid_o |->
    out_tcm_o == (SET_TABLE[out_sel_o].mode == MODE_TCM))
    else $error("set mode wrong");
  a_lanes_unused: assert property (out_valid_o |->
    hi_zero(rotated_symbol_lanes_o, out_n_coded_o))
    else $error("unused lane not zero");
  a_sel_range: assert property (out_valid_o |->
    out_sel_o < NUM_SETS) else $error("set index out of range");
  a_len_range: assert property (out_valid_o |->
    out_con_len_o >= L_MIN && out_con_len_o <= L_MAX)
    else $error("constraint length out of range");
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_full: cover property (!sym_ready_o);
  c_tcm: cover property (out_valid_o && out_tcm_o);
endmodule

bind tdcs_top tdcs_top_props #(.NUM_SETS(NUM_SETS)) u_props (
  .clk_sys_i, .sys_rst_i, .clk_en_i, .sym_valid_i, .sym_ready_o,
  .out_valid_o, .out_ready_i, .rotated_symbol_lanes_o, .out_sel_o,
  .out_n_coded_o, .out_con_len_o, .out_tcm_o, .num_err_o
);

// File: tb/tdcs_src_model.sv
// Upstream source of soft symbol words for the decoder
`timescale 1ns/10ps
module tdcs_src_model
  import tdcs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        clk_en_i,
  input  wire logic        ready_i,
  input  wire logic        slow_i,
  output logic             valid_o,
  output tdcs_word_t       word_o,
  output logic [NUM_W-1:0] off_o,
  output logic [END_W-1:0] end_o
);
  typedef struct packed {
    tdcs_word_t       w;
    logic [NUM_W-1:0] o;
    logic [END_W-1:0] e;
  } tdcs_req_t;
  tdcs_req_t q[$];
  tdcs_req_t r;
  logic      took = 1'b0;
  initial begin
    valid_o = 1'b0;
    word_o = '0;
    off_o = '0;
    end_o = '0;
  end
  task automatic send(tdcs_word_t w, logic [NUM_W-1:0] o,
                      logic [END_W-1:0] e);
    q.push_back({w, o, e});
  endtask
  always @(posedge clk_sys_i) took <= valid_o && ready_i && clk_en_i;
  // Word and its qualifiers held until the edge that takes them
  always @(negedge clk_sys_i) begin
    if (!valid_o || took) begin
      if (q.size() > 0 && !(slow_i && valid_o)) begin
        r = q.pop_front();
        valid_o <= 1'b1;
        {word_o, off_o, end_o} <= r;
      end else begin
        // Released lines toggle so stale data cannot pass for fresh
        valid_o <= 1'b0;
        {word_o, off_o, end_o} <= ~{word_o, off_o, end_o};
      end
    end
  end
endmodule

// File: tb/tdcs_top_bench.sv
// Self-checking bench of the code set, rotation and error count stage
`timescale 1ns/10ps
module tdcs_top_bench;
  import tdcs_pkg::*;
  typedef struct packed {
    tdcs_word_t w;
    logic [2:0] o;
    logic [7:0] e;
    logic [15:0] n;
    logic ck;
  } tdcs_exp_t;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1;
  logic out_ready_i = 1'b0, err_clear_i = 1'b0, stall = 1'b0, slow = 1'b0;
  logic sym_valid_i, sym_ready_o, out_valid_o, out_tcm_o;
  logic err_valid_o, cfg_error_o, best_state_en_o;
  tdcs_word_t w;
  logic [NUM_W-1:0] off, out_n_coded_o;
  logic [END_W-1:0] es, end_state_o;
  logic [LANES_MAX-1:0][SOFT_W-1:0] rotated_symbol_lanes_o;
  logic [SEL_W-1:0] out_sel_o;
  logic [LEN_W-1:0] out_con_len_o;
  logic [NPOLY-1:0][POLY_W-1:0] out_poly_o;
  logic [ERR_W-1:0] num_err_o, cnt = '0;
  logic [8:0] hist = '0;
  logic [31:0] lfsr = 32'h873D443E;
  int failures = 0, n_compared = 0;
  tdcs_exp_t exq[$];
  always #50 clk_sys_i = ~clk_sys_i;
  tdcs_top dut (
    .clk_sys_i, .sys_rst_i, .clk_en_i, .sym_valid_i, .sym_ready_o,
    .soft_symbol_lanes_in_i(w.lanes), .erase_i(w.erase),
    .dec_bit_i(w.info_bit), .sel_code_i(w.sel), .rot_offset_i(off),
    .trellis_end_state_in_i(es), .err_clear_i, .out_valid_o, .out_ready_i,
    .rotated_symbol_lanes_o, .out_sel_o, .out_n_coded_o, .out_con_len_o,
    .out_tcm_o, .out_poly_o, .end_state_o, .best_state_en_o,
    .num_err_o, .err_valid_o, .cfg_error_o
  );
  tdcs_src_model src (
    .clk_sys_i, .clk_en_i, .ready_i(sym_ready_o), .slow_i(slow),
    .valid_o(sym_valid_i), .word_o(w), .off_o(off), .end_o(es)
  );
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [27:0] rot(tdcs_word_t x, logic [2:0] o);
    int n = SET_TABLE[x.sel].n_coded;
    rot = '0;
    for (int i = 0; i < n; i++) rot[i*4 +: 4] = x.lanes[(o + i) % n];
  endfunction
  // Re-encode with history bit 0 as the newest bit; erased lanes skipped
  function automatic logic [15:0] mis(tdcs_word_t x, logic [8:0] h);
    tdcs_set_t s = SET_TABLE[x.sel];
    mis = '0;
    for (int p = 0; p < s.n_coded; p++)
      if (!x.erase[p] && x.lanes[p][SOFT_W-1] != ^(s.poly[p] & h))
        mis = mis + 16'h0001;
  endfunction
  // End state: last L-1 bits of the block, newest bit in the top place
  function automatic logic [7:0] rev_end(logic [8:0] h, logic [3:0] l);
    rev_end = '0;
    for (int j = 0; j < l - 1; j++) rev_end[j] = h[l - 2 - j];
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(logic [2:0] s, logic [2:0] o, logic [7:0] e, logic ck);
    tdcs_exp_t x;
    logic [63:0] r;
    r = {rnd(), rnd()};
    x.w = r[$bits(tdcs_word_t)-1:0];
    x.w.sel = s;
    x.o = o;
    x.e = e;
    x.ck = ck;
    if (ck) begin
      hist = {hist[7:0], x.w.info_bit};
      cnt = cnt + mis(x.w, hist);
      x.e = rev_end(hist, SET_TABLE[s].con_len);
    end
    x.n = cnt;
    exq.push_back(x);
    src.send(x.w, o, x.e);
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && exq.size() > 0; i++) @(negedge clk_sys_i);
    chk("drained", exq.size(), 0);
  endtask
  task automatic close_out();
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge clk_sys_i) begin
    clk_en_i <= sys_rst_i || rnd() % 8 != 0;
    out_ready_i <= !stall && rnd() % 4 != 0;
    slow <= rnd() % 4 == 0;
  end
  always @(posedge clk_sys_i) begin
    tdcs_exp_t x;
    tdcs_set_t s;
    if (!sys_rst_i && out_valid_o && out_ready_i && clk_en_i) begin
      x = exq.pop_front();
      s = SET_TABLE[x.w.sel];
      chk("lanes", rotated_symbol_lanes_o, rot(x.w, x.o));
      chk("sel", out_sel_o, x.w.sel);
      chk("n", out_n_coded_o, s.n_coded);
      chk("len", out_con_len_o, s.con_len);
      chk("tcm", out_tcm_o, s.mode == MODE_TCM);
      chk("poly", out_poly_o, s.poly);
      chk("end", end_state_o,
          s.con_len <= L_SMALL_MAX ? x.e & 8'h0F : x.e);
      chk("errv", err_valid_o, s.mode != MODE_TCM);
      if (x.ck) chk("nerr", num_err_o, x.n);
    end
  end
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    logic [2:0] sel;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk("cfg", cfg_error_o, 1'b0);
    chk("best", best_state_en_o, 1'b1);
    repeat (40) put(3'h3, 3'h0, 8'(rnd()), 1'b1);
    // Receiver stalls: two buffered words plus the output stage fill up
    stall = 1'b1;
    repeat (6) put(3'h3, 3'h0, 8'(rnd()), 1'b1);
    repeat (14) @(negedge clk_sys_i);
    chk("ready", sym_ready_o, 1'b0);
    stall = 1'b0;
    drain();
    err_clear_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    err_clear_i = 1'b0;
    cnt = '0;
    chk("clear", num_err_o, 16'h0000);
    repeat (30) put(3'h3, 3'h0, 8'(rnd()), 1'b1);
    drain();
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (int s = 0; s < NSETS; s++)
      put(3'(s), 3'(SET_TABLE[s].n_coded - 1), 8'hFF, 1'b0);
    repeat (150) begin
      sel = 3'(rnd());
      put(sel, 3'(rnd() % SET_TABLE[sel].n_coded), 8'(rnd()), 1'b0);
    end
    drain();
    close_out();
  end
endmodule
